/* common/irq_pkg.sv */
// Shared constants and carrier types of the single vector interrupt unit.
// Assumes one system clock domain; all event inputs are synchronous pulses.
package irq_pkg;

  // Source counts and flag bit layout
  localparam int NUM_SRC       = 46;
  localparam int NUM_GRP       = 9;
  localparam int SRC_WDT       = 0;
  localparam int SRC_RTC_TOD   = 1;
  localparam int SRC_RTC_SUB   = 2;
  localparam int SRC_EXT       = 3;
  localparam int NUM_EXT       = 16;
  localparam int SRC_UART0     = 19;
  localparam int SRC_UART1     = 21;
  localparam int NUM_UART_SRC  = 2;
  localparam int SRC_SPI       = 23;
  localparam int NUM_SPI_SRC   = 4;
  localparam int SRC_TMR0      = 27;
  localparam int NUM_TMR_SRC   = 4;
  localparam int NUM_TMR       = 3;
  localparam int SRC_OW        = 39;
  localparam int NUM_OW_SRC    = 7;
  localparam int NUM_SYS_SRC   = 3;

  // Group bits of the source id register
  localparam int GRP_SYS       = 0;
  localparam int GRP_EXT       = 1;
  localparam int GRP_UART0     = 2;
  localparam int GRP_UART1     = 3;
  localparam int GRP_SPI       = 4;
  localparam int GRP_TMR0      = 5;
  localparam int GRP_OW        = 8;

  // Flags raised by asynchronous logic (RTC alarms, external pins)
  localparam logic [NUM_SRC-1:0] ASYNC_MASK = 46'h0000_0007_FFFE;

  // Reset values
  localparam logic [15:0]        VECTOR_RESET = 16'h0000;
  localparam logic [NUM_SRC-1:0] FLAGS_RESET  = 46'h0;
  localparam logic [NUM_GRP-1:0] ID_RESET     = 9'h0;

  // Watchdog timing, in system clocks
  localparam int WDT_WARN_CLKS = 512;
  localparam int WDT_EXP_MIN   = 12;
  localparam int WDT_EXP_STEP  = 3;
  localparam int WDT_CNT_W     = 22;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_SERV = 2'b11
  } core_state_e;

  typedef struct packed {
    logic        rtc_tod;   // Time-of-day alarm
    logic        rtc_sub;   // Subsecond alarm
    logic [1:0]  uart_rx;   // Index = port number
    logic [1:0]  uart_tx;
    logic [3:0]  spi;       // 3 mode fault, 2 write collision, 1 overrun, 0 done
    logic [11:0] tmr;       // 4 per timer: 3 low cmp, 2 low ovf, 1 cap/cmp, 0 ovf
    logic [6:0]  ow;        // 6 presence .. 0 line low
  } periph_events_s;

  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } vector_write_s;

endpackage : irq_pkg

/* verilog/flag_bank.sv */
// Sticky interrupt flags with per-source enables and request drop timing.
// Assumes set and clear vectors are one-cycle pulses on the system clock.
`timescale 1ns/1ns
`default_nettype none
module flag_bank #(
  parameter int                   WIDTH = irq_pkg::NUM_SRC,
  parameter logic [WIDTH-1:0]     ASYNC = irq_pkg::ASYNC_MASK
) (
  input  wire logic             ref_clk,  // System clock
  input  wire logic             rst_n,    // Asynchronous reset, active low
  input  wire logic [WIDTH-1:0] set,      // Event pulses
  input  wire logic [WIDTH-1:0] clr,      // Flag clear pulses from software
  input  wire logic [WIDTH-1:0] src_en,   // Per-source enables
  output logic      [WIDTH-1:0] flags,    // Flag state
  output logic      [WIDTH-1:0] pend      // Enabled pending sources
);

  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;
  logic [WIDTH-1:0] pend_now;
  logic [WIDTH-1:0] pend_d_reg;

  // Set wins over a clear in the same cycle; enables do not gate the flag
  assign flag_next = (flag_reg & ~clr) | set;
  assign pend_now  = flag_reg & src_en;
  // Sync flags hold their request one cycle longer after a clear
  assign pend      = (pend_now & ASYNC) | ((pend_now | pend_d_reg) & ~ASYNC);
  assign flags     = flag_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg   <= '0;
      pend_d_reg <= '0;
    end else begin
      flag_reg   <= flag_next;
      pend_d_reg <= pend_now;
    end
  end

endmodule : flag_bank
`default_nettype wire

/* verilog/single_vector_interrupt_unit.sv */
// Single vector interrupt unit: flags, three enable levels, one vectored
// request to the core, source id register and watchdog early warning.
// Assumes the core acknowledges a request and pulses a return strobe.
//
// Notes on behaviour
// - Each flag sets on its event even when any enable level is off.
// - Global, module and per-source enables each can block a request.
// - All sources share one software-written vector handed to the core.
// - The vector register resets to 0000h.
// - A readable id register shows which group holds a pending source.
// - Request drops one cycle after clearing async flags, two for sync.
// - No hardware priority; software polls flags to order service.
// - Sixteen external interrupt inputs, 0 to 15, each with a flag.
// - SPI gives mode fault, write collision, overrun and done sources.
// - Timers 0 to 2 each give four interrupt sources.
// - Single-wire master gives seven interrupt sources.
// - Serial ports 0 and 1 give receive and transmit sources.
// - RTC time-of-day and subsecond alarms; either wakes from stop.
// - Watchdog interrupt comes 511 clocks before its system reset.
// - Every second-type port pin can raise an external interrupt.
`timescale 1ns/1ns
`default_nettype none
module single_vector_interrupt_unit #(
  parameter int WDT_EXP_MIN  = irq_pkg::WDT_EXP_MIN,    // Shortest timeout, as 2^n clocks
  parameter int WDT_EXP_STEP = irq_pkg::WDT_EXP_STEP,   // Exponent step per select value
  parameter int WDT_WARN     = irq_pkg::WDT_WARN_CLKS   // Warning lead before reset
) (
  input  wire logic                            ref_clk,      // System clock, 50 MHz
  input  wire logic                            rst_n,        // Asynchronous reset, active low
  input  wire irq_pkg::periph_events_s         periph_evt,   // Peripheral event pulses
  input  wire logic [irq_pkg::NUM_EXT-1:0]     ext_pin,      // Port pins with interrupt use
  input  wire logic [irq_pkg::NUM_EXT-1:0]     ext_fall,     // 1: falling edge, 0: rising
  input  wire logic                            glob_en,      // Global interrupt enable
  input  wire logic [irq_pkg::NUM_GRP-1:0]     mod_en,       // Module enables
  input  wire logic [irq_pkg::NUM_SRC-1:0]     src_en,       // Per-source enables
  input  wire logic [irq_pkg::NUM_SRC-1:0]     flag_clr,     // Flag clear pulses
  input  wire irq_pkg::vector_write_s          vec_wr,       // Vector register write
  input  wire logic                            core_ack,     // Core took the request
  input  wire logic                            return_from_interrupt, // End of service
  input  wire logic                            wdt_run,      // Watchdog counting
  input  wire logic                            wdt_restart,  // Software restarts watchdog
  input  wire logic [1:0]                      wdt_sel,      // Timeout select
  output logic                                 irq_req,      // Request to the core
  output logic [15:0]                          interrupt_vector_register, // Service address
  output logic [irq_pkg::NUM_GRP-1:0]          interrupt_source_id_register, // Pending groups
  output logic [irq_pkg::NUM_SRC-1:0]          flags_out,    // All source flags
  output logic                                 stop_wake,    // Wake pulse out of stop
  output logic                                 wdt_sys_reset // Watchdog reset pulse
);

  localparam int NS = irq_pkg::NUM_SRC;
  localparam int NG = irq_pkg::NUM_GRP;
  localparam int CW = irq_pkg::WDT_CNT_W;

  // OR of a field of the pending vector
  function automatic logic field_any(input logic [NS-1:0] v, input int lo, input int n);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NS; i++) begin
      if (i >= lo && i < lo + n) begin
        r = r | v[i];
      end
    end
    return r;
  endfunction : field_any

  // Watchdog period for a select value
  function automatic logic [CW-1:0] wdt_period(input logic [1:0] sel);
    return CW'(1) << (WDT_EXP_MIN + WDT_EXP_STEP * int'(sel));
  endfunction : wdt_period

  // ---------------- External pins ----------------
  logic [irq_pkg::NUM_EXT-1:0] ext_prev_reg;
  logic [irq_pkg::NUM_EXT-1:0] ext_rise;
  logic [irq_pkg::NUM_EXT-1:0] ext_fall_det;
  logic [irq_pkg::NUM_EXT-1:0] ext_evt;

  assign ext_rise     = ext_pin & ~ext_prev_reg;
  assign ext_fall_det = ~ext_pin & ext_prev_reg;
  assign ext_evt      = (ext_fall & ext_fall_det) | (~ext_fall & ext_rise);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_reg <= '0;
    end else begin
      ext_prev_reg <= ext_pin;
    end
  end

  // ---------------- Watchdog ----------------
  logic [CW-1:0] wdt_cnt_reg;
  logic [CW-1:0] wdt_cnt_next;
  logic [CW-1:0] wdt_per;
  logic          wdt_warn_hit;
  logic          wdt_end_hit;
  logic          wdt_rst_reg;

  assign wdt_per      = wdt_period(wdt_sel);
  assign wdt_warn_hit = wdt_run && (wdt_cnt_reg == wdt_per - CW'(WDT_WARN));
  assign wdt_end_hit  = wdt_run && (wdt_cnt_reg == wdt_per - CW'(1));
  assign wdt_cnt_next = (wdt_restart || wdt_end_hit || !wdt_run) ? '0
                        : wdt_cnt_reg + CW'(1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_reg <= '0;
      wdt_rst_reg <= 1'b0;
    end else begin
      wdt_cnt_reg <= wdt_cnt_next;
      wdt_rst_reg <= wdt_end_hit && !wdt_restart;
    end
  end

  // ---------------- Flag set vector ----------------
  logic [NS-1:0] set_vec;

  assign set_vec[irq_pkg::SRC_WDT]     = wdt_warn_hit && !wdt_restart;
  assign set_vec[irq_pkg::SRC_RTC_TOD] = periph_evt.rtc_tod;
  assign set_vec[irq_pkg::SRC_RTC_SUB] = periph_evt.rtc_sub;
  assign set_vec[irq_pkg::SRC_EXT +: irq_pkg::NUM_EXT] = ext_evt;
  assign set_vec[irq_pkg::SRC_UART0 +: irq_pkg::NUM_UART_SRC] =
    {periph_evt.uart_tx[0], periph_evt.uart_rx[0]};
  assign set_vec[irq_pkg::SRC_UART1 +: irq_pkg::NUM_UART_SRC] =
    {periph_evt.uart_tx[1], periph_evt.uart_rx[1]};
  assign set_vec[irq_pkg::SRC_SPI +: irq_pkg::NUM_SPI_SRC] = periph_evt.spi;
  assign set_vec[irq_pkg::SRC_TMR0 +: irq_pkg::NUM_TMR_SRC * irq_pkg::NUM_TMR] =
    periph_evt.tmr;
  assign set_vec[irq_pkg::SRC_OW +: irq_pkg::NUM_OW_SRC] = periph_evt.ow;

  // ---------------- Flags ----------------
  logic [NS-1:0] flags;
  logic [NS-1:0] pend;

  flag_bank #(
    .WIDTH (NS),
    .ASYNC (irq_pkg::ASYNC_MASK)
  ) u_flags (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .set     (set_vec),
    .clr     (flag_clr),
    .src_en  (src_en),
    .flags   (flags),
    .pend    (pend)
  );

  // ---------------- Group pending and request ----------------
  logic [NG-1:0] grp_raw;
  logic [NG-1:0] grp_pend;
  logic          req_any;

  assign grp_raw[irq_pkg::GRP_SYS]   = field_any(pend, irq_pkg::SRC_WDT, irq_pkg::NUM_SYS_SRC);
  assign grp_raw[irq_pkg::GRP_EXT]   = field_any(pend, irq_pkg::SRC_EXT, irq_pkg::NUM_EXT);
  assign grp_raw[irq_pkg::GRP_UART0] = field_any(pend, irq_pkg::SRC_UART0,
                                                 irq_pkg::NUM_UART_SRC);
  assign grp_raw[irq_pkg::GRP_UART1] = field_any(pend, irq_pkg::SRC_UART1,
                                                 irq_pkg::NUM_UART_SRC);
  assign grp_raw[irq_pkg::GRP_SPI]   = field_any(pend, irq_pkg::SRC_SPI, irq_pkg::NUM_SPI_SRC);
  assign grp_raw[irq_pkg::GRP_TMR0]     = field_any(pend, irq_pkg::SRC_TMR0,
                                                    irq_pkg::NUM_TMR_SRC);
  assign grp_raw[irq_pkg::GRP_TMR0 + 1] = field_any(pend,
                                                    irq_pkg::SRC_TMR0 + irq_pkg::NUM_TMR_SRC,
                                                    irq_pkg::NUM_TMR_SRC);
  assign grp_raw[irq_pkg::GRP_TMR0 + 2] = field_any(pend,
                                                    irq_pkg::SRC_TMR0 + 2 * irq_pkg::NUM_TMR_SRC,
                                                    irq_pkg::NUM_TMR_SRC);
  assign grp_raw[irq_pkg::GRP_OW]    = field_any(pend, irq_pkg::SRC_OW, irq_pkg::NUM_OW_SRC);

  // All sources funnel into one request; no ordering among them
  assign grp_pend = grp_raw & mod_en;
  assign req_any  = glob_en && (|grp_pend);

  // ---------------- Core handshake ----------------
  irq_pkg::core_state_e state_reg;
  irq_pkg::core_state_e state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      irq_pkg::ST_IDLE: begin
        if (req_any) begin
          state_next = irq_pkg::ST_REQ;
        end
      end
      irq_pkg::ST_REQ: begin
        if (!req_any) begin
          state_next = irq_pkg::ST_IDLE;
        end else if (core_ack) begin
          state_next = irq_pkg::ST_SERV;
        end
      end
      irq_pkg::ST_SERV: begin
        if (return_from_interrupt) begin
          state_next = irq_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = irq_pkg::ST_IDLE;
      end
    endcase
  end

  logic [15:0]   vec_reg;
  logic [NG-1:0] id_reg;
  logic          req_reg;
  logic          wake_reg;
  logic [NS-1:0] flags_reg;
  logic          wake_evt;

  assign wake_evt = periph_evt.rtc_tod || periph_evt.rtc_sub
                    || (mod_en[irq_pkg::GRP_EXT]
                        && |(ext_evt & src_en[irq_pkg::SRC_EXT +: irq_pkg::NUM_EXT]));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= irq_pkg::ST_IDLE;
      req_reg   <= 1'b0;
      vec_reg   <= irq_pkg::VECTOR_RESET;
      id_reg    <= irq_pkg::ID_RESET;
      wake_reg  <= 1'b0;
      flags_reg <= irq_pkg::FLAGS_RESET;
    end else begin
      state_reg <= state_next;
      req_reg   <= (state_next == irq_pkg::ST_REQ);
      if (vec_wr.wr) begin
        vec_reg <= vec_wr.data;
      end
      id_reg    <= grp_pend;
      wake_reg  <= wake_evt;
      flags_reg <= flags;
    end
  end

  assign irq_req                      = req_reg;
  assign interrupt_vector_register    = vec_reg;
  assign interrupt_source_id_register = id_reg;
  assign flags_out                    = flags_reg;
  assign stop_wake                    = wake_reg;
  assign wdt_sys_reset                = wdt_rst_reg;

endmodule : single_vector_interrupt_unit
`default_nettype wire

/* tb/svi_props.sv */
// Port checker for the single vector interrupt unit.
// Assumes it is bound into single_vector_interrupt_unit on one clock.
`timescale 1ns/1ns
`default_nettype none
module svi_props (
  input wire logic                        ref_clk,    // Clock
  input wire logic                        rst_n,      // Reset
  input wire irq_pkg::periph_events_s     periph_evt, // Events
  input wire logic                        glob_en,    // Global enable
  input wire irq_pkg::vector_write_s      vec_wr,     // Vector write
  input wire logic                        core_ack,   // Core take
  input wire logic                        irq_req,    // Request
  input wire logic [15:0]                 interrupt_vector_register,    // Vector
  input wire logic [irq_pkg::NUM_GRP-1:0] interrupt_source_id_register, // Groups
  input wire logic [irq_pkg::NUM_SRC-1:0] flags_out,  // Flags
  input wire logic                        stop_wake   // Wake
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    irq_req && core_ack;
  endsequence
  sequence s_tod;
    periph_evt.rtc_tod;
  endsequence
  a_vec_reset: assert property ($rose(rst_n) |-> interrupt_vector_register == 16'h0000)
    else $error("Vector not zero after reset");
  a_vec_load: assert property (vec_wr.wr |=> interrupt_vector_register == $past(vec_wr.data))
    else $error("Vector write not taken");
  a_tod_flag: assert property (s_tod |-> ##2 flags_out[irq_pkg::SRC_RTC_TOD])
    else $error("Alarm flag not set");
  a_wire_flag: assert property (periph_evt.ow[0] |-> ##2 flags_out[irq_pkg::SRC_OW])
    else $error("Single-wire flag not set");
  a_glob_block: assert property (!glob_en [*5] |-> !irq_req)
    else $error("Request with global enable off");
  a_quiet_no_req: assert property ((flags_out == '0) [*3] |-> !irq_req)
    else $error("Request without any flag");
  a_id_on_req: assert property ($rose(irq_req) |-> interrupt_source_id_register != '0)
    else $error("Request with empty id");
  a_ack_drops: assert property (s_take |=> !irq_req)
    else $error("Request held after take");
  a_alarm_wake: assert property (s_tod |=> stop_wake)
    else $error("No wake after alarm");
endmodule : svi_props
bind single_vector_interrupt_unit svi_props u_svi_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .periph_evt(periph_evt), .glob_en(glob_en),
  .vec_wr(vec_wr), .core_ack(core_ack), .irq_req(irq_req),
  .interrupt_vector_register(interrupt_vector_register),
  .interrupt_source_id_register(interrupt_source_id_register),
  .flags_out(flags_out), .stop_wake(stop_wake));
`default_nettype wire

/* tb/core_model.sv */
// Processor core model: takes a request after a set delay, then returns.
// Assumes the bench clears flags during the service window.
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input  wire logic       ref_clk,              // Clock
  input  wire logic       rst_n,                // Reset
  input  wire logic       irq_req,              // Request
  input  wire logic [3:0] dly,                  // Take delay
  output logic            core_ack,             // Take pulse
  output logic            return_from_interrupt // End pulse
);
  int   cnt;
  logic serv;
  always @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      serv <= 1'h0;
      core_ack <= 1'h0;
      return_from_interrupt <= 1'h0;
    end else begin
      core_ack <= 1'h0;
      return_from_interrupt <= 1'h0;
      if (serv) begin
        cnt <= cnt + 1;
        if (cnt == 5) begin
          return_from_interrupt <= 1'h1;
          serv <= 1'h0;
          cnt <= 0;
        end
      end else if (!irq_req) begin
        cnt <= 0;
      end else if (cnt >= dly) begin
        core_ack <= 1'h1;
        serv <= 1'h1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : core_model
`default_nettype wire

/* tb/single_vector_interrupt_unit_bench.sv */
// Self-checking bench for the single vector interrupt unit.
// Assumes the core model in core_model.sv; watchdog shortened to 2^10.
`timescale 1ns/1ns
`default_nettype none
module single_vector_interrupt_unit_bench;
  logic ref_clk, rst_n, glob_en, core_ack, rfi, wdt_run, wdt_restart;
  logic irq_req, stop_wake, wdt_sys_reset, pol;
  logic [15:0] ext_pin, ext_fall, vec, d;
  logic [45:0] src_en, flag_clr, flags;
  logic [8:0] mod_en, id;
  logic [3:0] dly;
  logic [2:0] en;
  logic [1:0] wdt_sel;
  irq_pkg::periph_events_s periph_evt;
  irq_pkg::vector_write_s vec_wr;
  int miscompares = 0, tests_run = 0, cyc = 0, t1, f, g;
  single_vector_interrupt_unit #(.WDT_EXP_MIN(10)) u_single_vector_interrupt_unit (
    .ref_clk(ref_clk), .rst_n(rst_n), .periph_evt(periph_evt), .ext_pin(ext_pin),
    .ext_fall(ext_fall), .glob_en(glob_en), .mod_en(mod_en), .src_en(src_en),
    .flag_clr(flag_clr), .vec_wr(vec_wr), .core_ack(core_ack),
    .return_from_interrupt(rfi), .wdt_run(wdt_run), .wdt_restart(wdt_restart),
    .wdt_sel(wdt_sel), .irq_req(irq_req), .interrupt_vector_register(vec),
    .interrupt_source_id_register(id), .flags_out(flags), .stop_wake(stop_wake),
    .wdt_sys_reset(wdt_sys_reset));
  core_model u_core_model (.ref_clk(ref_clk), .rst_n(rst_n), .irq_req(irq_req),
    .dly(dly), .core_ack(core_ack), .return_from_interrupt(rfi));
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  // Flag index of a bit of the peripheral event vector
  function automatic int fidx(int b);
    if (b < 7) return 39 + b;
    if (b < 19) return 20 + b;
    if (b < 23) return 4 + b;
    if (b < 25) return 20 + 2 * (b - 23);
    if (b < 27) return 19 + 2 * (b - 25);
    return 29 - b;
  endfunction : fidx
  function automatic int grp(int x);
    if (x < 3) return 0;
    if (x < 19) return 1;
    if (x < 23) return 2 + (x - 19) / 2;
    if (x < 27) return 4;
    if (x < 39) return 5 + (x - 27) / 4;
    return 8;
  endfunction : grp
  task automatic nc(int n);
    repeat (n) @(negedge ref_clk);
  endtask : nc
  task automatic chk(string nm, logic [45:0] exp, logic [45:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %0h got %0h", nm, exp, got);
    end
  endtask : chk
  task automatic clr(int x);
    flag_clr[x] = 1'h1;
    nc(1);
    flag_clr = '0;
  endtask : clr
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end
  initial begin
    {rst_n, glob_en, wdt_run, wdt_restart, wdt_sel, dly} = '0;
    {ext_pin, ext_fall, mod_en, src_en, flag_clr, periph_evt, vec_wr} = '0;
    void'($urandom(49157));
    nc(20);
    rst_n = 1'h1;
    nc(1);
    chk("vec0", 46'h0, 46'(vec));
    chk("flags0", 46'h0, flags);
    for (int b = 0; b < 29; b++) begin
      f = fidx(b);
      g = grp(f);
      en = (b % 4 == 0) ? 3'h7 : 3'($urandom_range(7, 0));
      glob_en = en[0];
      mod_en = 9'($urandom);
      mod_en[g] = en[1];
      src_en = 46'({$urandom, $urandom});
      src_en[f] = en[2];
      dly = 4'($urandom_range(6, 0));
      periph_evt[b] = 1'h1;
      nc(1);
      periph_evt = '0;
      nc(1);
      chk("flag", 46'h1 << f, flags);
      chk("req", 46'(&en), 46'(irq_req));
      if (&en) chk("id", 46'h1 << g, 46'(id));
      nc(dly + 2);
      clr(f);
      nc(8);
      chk("clear", 46'h0, flags);
      chk("idle", 46'h0, 46'(irq_req));
    end
    {glob_en, mod_en, src_en} = '1;
    dly = 4'hF;
    for (int k = 0; k < 2; k++) begin
      f = k ? 0 : 28;
      periph_evt[f] = 1'h1;
      nc(1);
      periph_evt = '0;
      nc(3);
      clr(fidx(f));
      chk("drop1", 46'h1, 46'(irq_req));
      nc(1);
      chk("drop2", 46'(k), 46'(irq_req));
      nc(1);
      chk("drop3", 46'h0, 46'(irq_req));
      nc(4);
    end
    dly = 4'h0;
    for (int i = 0; i < 16; i++) begin
      pol = 1'($urandom_range(1, 0));
      ext_fall[i] = pol;
      ext_pin[i] = pol;
      nc(3);
      clr(3 + i);
      nc(8);
      ext_pin[i] = ~pol;
      nc(1);
      chk("wake", 46'h1, 46'(stop_wake));
      nc(3);
      chk("ext", 46'h1 << (3 + i), flags);
      clr(3 + i);
      nc(8);
    end
    for (int v = 0; v < 4; v++) begin
      d = 16'($urandom);
      vec_wr = '{wr: 1'h1, data: d};
      nc(1);
      vec_wr = '0;
      chk("vec", 46'(d), 46'(vec));
    end
    glob_en = 1'h0;
    for (int s = 0; s < 2; s++) begin
      wdt_sel = 2'(s);
      wdt_run = 1'h1;
      t1 = 0;
      g = cyc;
      repeat (9000) begin
        @(negedge ref_clk);
        if (flags[0] && t1 == 0) t1 = cyc;
        if (wdt_sys_reset) break;
      end
      // Flag view lags the internal flag by one clock
      chk("wdt", 46'(irq_pkg::WDT_WARN_CLKS - 2), 46'(cyc - t1));
      chk("wdt_per", 46'h1 << (10 + irq_pkg::WDT_EXP_STEP * s), 46'(cyc - g));
      wdt_run = 1'h0;
      clr(0);
      nc(2);
    end
    rst_n = 1'h0;
    nc(2);
    chk("vec_rst", 46'h0, 46'(vec));
    rst_n = 1'h1;
    nc(2);
    wrap_up();
  end
endmodule : single_vector_interrupt_unit_bench
`default_nettype wire
